//--- rtl/hbc_ctrl.sv
/*
 Host-side controller for a three-phase half-bridge gate driver.
 Takes a requested upper/lower command per phase, inserts dead time,
 enforces least pulse widths, drives the command pins always, watches
 the shared open-drain fault/shutdown line and may pull it low itself.
 Assumes all inputs but the fault line synchronous to ref_clk, a board pull-up on the line.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - At least 1.5 us dead time
// - Every command pulse at least 0.5 us unless a fault or shutdown cuts it
// - Carrier ticks closer than 20 kHz allows are flagged
// - Command pins always actively driven
// - All commands low within 15 us while clk_en is high
// - Shutdown pulses at least 3.0 us
// - Tied lines stop all three phases
module hbc_ctrl
   import hbc_pkg::*;
#(
   parameter int NPHASE = HBC_NPHASE
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire hbc_cmd_t [NPHASE-1:0] cmd_req,
   input wire logic period_tick,
   input wire logic shutdown_req,
   input wire logic fault_shutdown_line_in,
   output hbc_cmd_t [NPHASE-1:0] gate_cmd,
   output logic fault_shutdown_line_out,
   output logic fault_shutdown_line_oe,
   output logic fault_seen,
   output logic period_error
);
   // Refused at elaboration: a phase count outside what the timers and
   // the checker serve, dead, period or shutdown counts that the counter width
   // cannot hold, or a zero dead, pulse or shutdown count (it would underflow the reload value)
   if (NPHASE < 1 || NPHASE > 8) begin : g_bad_nphase
      $error("hbc_ctrl: NPHASE out of range");
   end
   if (HBC_DEAD_CYC < 1 || HBC_PULSE_CYC < 1 || HBC_SHUT_CYC < 1 ||
       HBC_MIN_PERIOD_CYC >= (1 << HBC_CW) ||
       HBC_DEAD_CYC >= (1 << HBC_CW) ||
       HBC_SHUT_CYC >= (1 << HBC_CW)) begin : g_bad_count
      $error("hbc_ctrl: timing count does not fit the timer width");
   end

   typedef enum logic [1:0] {HBC_OFF, HBC_DEAD, HBC_UP, HBC_LO} hbc_st_t;

   function automatic logic [HBC_CW-1:0] dec_sat(input logic [HBC_CW-1:0] v);
      dec_sat = (v == '0) ? v : v - 16'h0001;
   endfunction : dec_sat

   // Fault line synchroniser; stage one feeds stage two only
   logic sync1_q, sync1_d, sync2_q, sync2_d;
   // Own shutdown drive and its pulse-width counter
   logic shut_q, shut_d;
   logic [HBC_CW-1:0] shut_cnt_q, shut_cnt_d;
   // Open-drain data level, registered so the port comes from a flop
   logic line_lo_q, line_lo_d;
   // Carrier period watch
   logic [HBC_CW-1:0] per_cnt_q, per_cnt_d;
   logic per_err_q, per_err_d;
   logic fault_seen_q, fault_seen_d;
   hbc_st_t st_q [NPHASE], st_d [NPHASE];
   logic [HBC_CW-1:0] tmr_q [NPHASE], tmr_d [NPHASE];
   hbc_cmd_t [NPHASE-1:0] out_q, out_d;
   logic kill;

   assign kill = ~sync2_q | shut_q;

   // Two-stage synchroniser on the shared line; the flag follows it or the own shutdown drive
   always_comb begin
      sync1_d = fault_shutdown_line_in;
      sync2_d = sync1_q;
      fault_seen_d = ~sync2_q | shut_q;
   end

   // Own shutdown request kept for at least the least pulse width, so a
   // one-cycle request still gives the device a legal shutdown pulse;
   // the price is that a release may be seen up to 3 us late
   always_comb begin
      shut_d = shut_q;
      shut_cnt_d = dec_sat(shut_cnt_q);
      // The line is only ever pulled low; the enable does the work
      line_lo_d = 1'b0;
      if (shut_cnt_q == '0 && shutdown_req != shut_q) begin
         shut_d = shutdown_req;
         shut_cnt_d = HBC_CW'(HBC_SHUT_CYC - 1);
      end
   end

   // Ticks closer than the shortest carrier period are flagged; the
   // flag is sticky so that a single short period is never lost
   always_comb begin
      per_cnt_d = dec_sat(per_cnt_q);
      per_err_d = per_err_q;
      if (period_tick) begin
         if (per_cnt_q != '0) begin
            per_err_d = 1'b1;
         end
         per_cnt_d = HBC_CW'(HBC_MIN_PERIOD_CYC - 1);
      end
   end

   // Per phase: off -> dead -> one side on; never both on
   always_comb begin
      for (int p = 0; p < NPHASE; p++) begin
         st_d[p] = st_q[p];
         tmr_d[p] = dec_sat(tmr_q[p]);
         out_d[p] = out_q[p];
         unique case (st_q[p])
            HBC_OFF: begin
               if (!kill && tmr_q[p] == '0 &&
                   (cmd_req[p].upper ^ cmd_req[p].lower)) begin
                  st_d[p] = HBC_DEAD;
                  tmr_d[p] = HBC_CW'(HBC_DEAD_CYC - 1);
               end
            end
            HBC_DEAD: begin
               if (kill || !(cmd_req[p].upper ^ cmd_req[p].lower)) begin
                  st_d[p] = HBC_OFF;
                  tmr_d[p] = '0;
               end else if (tmr_q[p] == '0) begin
                  st_d[p] = cmd_req[p].upper ? HBC_UP : HBC_LO;
                  out_d[p].upper = cmd_req[p].upper;
                  out_d[p].lower = cmd_req[p].lower;
                  tmr_d[p] = HBC_CW'(HBC_PULSE_CYC - 1);
               end
            end
            HBC_UP, HBC_LO: begin
               if (kill) begin
                  // Fault overrides the pulse width floor
                  st_d[p] = HBC_OFF;
                  out_d[p] = '0;
                  tmr_d[p] = HBC_CW'(HBC_DEAD_CYC - 1);
               end else if (tmr_q[p] == '0 &&
                  ((st_q[p] == HBC_UP) ? !cmd_req[p].upper
                                        : !cmd_req[p].lower)) begin
                  st_d[p] = HBC_OFF;
                  out_d[p] = '0;
                  // Off time also at least the dead time (>= pulse width)
                  tmr_d[p] = HBC_CW'(HBC_DEAD_CYC - 1);
               end
            end
         endcase
      end
   end

   // Synchroniser resets to the pulled-up idle level, so no false fault
   // follows reset. A low line reaches the pins three edges later: two
   // for the synchroniser and one for the output register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         fault_seen_q <= 1'b0;
      end else if (clk_en) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         fault_seen_q <= fault_seen_d;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shut_q <= 1'b0;
         shut_cnt_q <= '0;
         line_lo_q <= 1'b0;
      end else if (clk_en) begin
         shut_q <= shut_d;
         shut_cnt_q <= shut_cnt_d;
         line_lo_q <= line_lo_d;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         per_cnt_q <= '0;
         per_err_q <= 1'b0;
      end else if (clk_en) begin
         per_cnt_q <= per_cnt_d;
         per_err_q <= per_err_d;
      end
   end

   // Command pins leave reset low and are always driven, never floated
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= '0;
         for (int p = 0; p < NPHASE; p++) begin
            st_q[p] <= HBC_OFF;
            tmr_q[p] <= '0;
         end
      end else if (clk_en) begin
         out_q <= out_d;
         for (int p = 0; p < NPHASE; p++) begin
            st_q[p] <= st_d[p];
            tmr_q[p] <= tmr_d[p];
         end
      end
   end

   assign gate_cmd = out_q;
   assign fault_shutdown_line_out = line_lo_q;
   assign fault_shutdown_line_oe = shut_q;
   assign fault_seen = fault_seen_q;
   assign period_error = per_err_q;
endmodule : hbc_ctrl

`default_nettype wire

//--- rtl/hbc_pkg.sv
/*
 Package for the half-bridge command controller: timing figures,
 derived cycle counts, phase count and the per-phase command struct.
 Assumes a 40 MHz reference clock.
*/
package hbc_pkg;
   localparam int HBC_CLK_MHZ = 40;
   localparam int HBC_NPHASE = 3;
   // Times in nanoseconds and the carrier limit in hertz, as printed
   localparam int HBC_DEAD_NS = 1500;
   localparam int HBC_PULSE_NS = 500;
   localparam int HBC_FAULT_BUDGET_NS = 15000;
   localparam int HBC_SHUT_PULSE_NS = 3000;
   localparam int HBC_CARRIER_MAX_HZ = 20000;
   // Least times round up to whole cycles
   localparam int HBC_DEAD_CYC = (HBC_DEAD_NS * HBC_CLK_MHZ + 999) / 1000;
   localparam int HBC_PULSE_CYC = (HBC_PULSE_NS * HBC_CLK_MHZ + 999) / 1000;
   localparam int HBC_SHUT_CYC =
      (HBC_SHUT_PULSE_NS * HBC_CLK_MHZ + 999) / 1000;
   // Longest time rounds down
   localparam int HBC_FAULT_BUDGET_CYC =
      HBC_FAULT_BUDGET_NS * HBC_CLK_MHZ / 1000;
   // Shortest carrier period in cycles
   localparam int HBC_MIN_PERIOD_CYC =
      (HBC_CLK_MHZ * 1000000 + HBC_CARRIER_MAX_HZ - 1) / HBC_CARRIER_MAX_HZ;
   localparam int HBC_CW = 16;

   typedef struct packed {
      logic upper;
      logic lower;
   } hbc_cmd_t;
endpackage : hbc_pkg

//--- testbench/hbc_ctrl_monitor.sv
/* Checker on the controller ports. Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
module hbc_ctrl_monitor
   import hbc_pkg::*;
#(
   parameter int NPHASE = 3
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire hbc_cmd_t [NPHASE-1:0] cmd_req,
   input wire logic period_tick,
   input wire logic shutdown_req,
   input wire logic fault_shutdown_line_in,
   input wire hbc_cmd_t [NPHASE-1:0] gate_cmd,
   input wire logic fault_shutdown_line_out,
   input wire logic fault_shutdown_line_oe,
   input wire logic fault_seen,
   input wire logic period_error
);
   logic [7:0] off_q;
   logic [7:0] on_q;
   logic [7:0] lvl_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Saturating counts; the first shutdown after reset is free
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         off_q <= 8'h00;
         on_q <= 8'h00;
         lvl_q <= 8'hFF;
      end else begin
         off_q <= (gate_cmd[0] != 2'h0) ? 8'h00 : off_q + (off_q != 8'hFF);
         on_q <= gate_cmd[0].upper ? on_q + (on_q != 8'hFF) : 8'h00;
         lvl_q <= $changed(fault_shutdown_line_oe) ? 8'h00 :
            lvl_q + (lvl_q != 8'hFF);
      end
   end
   sequence s_cut;
      ##3 (gate_cmd == '0 && fault_seen);
   endsequence
   dead_time_a: assert property ($rose(gate_cmd[0].upper) ||
      $rose(gate_cmd[0].lower) |-> off_q >= HBC_DEAD_CYC - 1)
      else $error("short dead time");
   min_pulse_a: assert property ($fell(gate_cmd[0].upper) && !fault_seen
      |-> on_q >= HBC_PULSE_CYC - 1) else $error("short pulse");
   no_overlap_a: assert property ((gate_cmd & (gate_cmd >> 1)
      & {NPHASE{2'h1}}) == '0) else $error("both gates on");
   fault_cut_a: assert property ($fell(fault_shutdown_line_in) |-> s_cut)
      else $error("fault not cut");
   fault_hold_a: assert property (fault_seen |-> gate_cmd == '0)
      else $error("gate on in fault");
   open_drain_a: assert property (fault_shutdown_line_out == 1'b0)
      else $error("line driven high");
   shut_width_a: assert property ($changed(fault_shutdown_line_oe) |->
      lvl_q >= HBC_SHUT_CYC - 1) else $error("short shutdown");
   sticky_err_a: assert property (period_error |=> period_error)
      else $error("error cleared");
endmodule : hbc_ctrl_monitor
bind hbc_ctrl hbc_ctrl_monitor #(.NPHASE(NPHASE)) u_mon (.ref_clk(ref_clk),
   .reset_n(reset_n), .clk_en(clk_en), .cmd_req(cmd_req),
   .period_tick(period_tick), .shutdown_req(shutdown_req),
   .fault_shutdown_line_in(fault_shutdown_line_in), .gate_cmd(gate_cmd),
   .fault_shutdown_line_out(fault_shutdown_line_out),
   .fault_shutdown_line_oe(fault_shutdown_line_oe),
   .fault_seen(fault_seen), .period_error(period_error));
`default_nettype wire

//--- testbench/hbc_dev_model.sv
/* Gate driver model: three phases, one wired fault line.
   Assumes the controller pins and its pull-low enable. */
`timescale 1ns/1ps
`default_nettype none
module hbc_dev_model
   import hbc_pkg::*;
#(
   parameter int BLANK = 66,
   parameter int HOLD = 1040
) (
   input wire logic ref_clk,
   input wire hbc_cmd_t [2:0] pins,
   input wire logic oc_sense,
   input wire logic up_lock,
   input wire logic ctrl_oe,
   output logic line,
   output hbc_cmd_t [2:0] drive
);
   int blank_q = 0;
   int hold_q = 0;
   logic both_on;
   always_ff @(posedge ref_clk) begin
      blank_q <= oc_sense ? blank_q + 1 : 0;
      hold_q <= (blank_q == BLANK) ? HOLD :
         (hold_q > 0 ? hold_q - 1 : 0);
   end
   assign both_on = |(pins & (pins >> 1) & 6'h15);
   // Board pull-up wins unless some party pulls low
   assign line = !(both_on || hold_q > 0 || ctrl_oe);
   always_comb begin
      drive = line ? pins : '0;
      // Upper lockout drops only the upper gates and leaves the line alone
      for (int p = 0; p < 3; p++) begin
         drive[p].upper = drive[p].upper & ~up_lock;
      end
   end
endmodule : hbc_dev_model
`default_nettype wire

//--- testbench/tb.sv
/* Bench: controller against the driver model. Assumes 40 MHz. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
   bad_count++; $display("mismatch %0t value", $time); end end
module tb
   import hbc_pkg::*;
;
   logic ref_clk = 0;
   logic reset_n = 0;
   logic period_tick = 0;
   logic shutdown_req = 0;
   logic oc_sense = 0;
   logic clk_en = 1'b1;
   logic up_lock = 1'b0;
   logic line, oe, fault_seen, period_error;
   hbc_cmd_t [2:0] cmd_req = '0;
   hbc_cmd_t [2:0] gate_cmd, drive;
   int bad_count = 0;
   int comparisons = 0;
   int ticks = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   hbc_ctrl #(.NPHASE(3)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .clk_en(clk_en), .cmd_req(cmd_req), .period_tick(period_tick),
      .shutdown_req(shutdown_req), .fault_shutdown_line_in(line),
      .gate_cmd(gate_cmd), .fault_shutdown_line_out(),
      .fault_shutdown_line_oe(oe), .fault_seen(fault_seen),
      .period_error(period_error));
   hbc_dev_model u_dev (.ref_clk(ref_clk), .pins(gate_cmd),
      .oc_sense(oc_sense), .up_lock(up_lock), .ctrl_oe(oe), .line(line),
      .drive(drive));
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic final_report();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic t_dead();
      `CHK(gate_cmd, 6'h00)
      cmd_req[0].upper = 1'b1;
      cmd_req[1].lower = 1'b1;
      cyc(HBC_DEAD_CYC);
      `CHK(gate_cmd[0].upper, 1'b0)
      cyc(1);
      `CHK(gate_cmd[0].upper, 1'b1)
      `CHK(drive[1].lower, 1'b1)
      // Request dropped at once: the pin must still stand its least width
      cmd_req[0].upper = 1'b0;
      up_lock = 1'b1;
      cyc(HBC_PULSE_CYC - 1);
      `CHK(gate_cmd[0].upper, 1'b1)
      `CHK(drive[0].upper, 1'b0)
      `CHK(line, 1'b1)
      up_lock = 1'b0;
      cyc(1);
      `CHK(gate_cmd[0].upper, 1'b0)
   endtask : t_dead
   task automatic t_fault();
      oc_sense = 1'b1;
      cyc(75);
      oc_sense = 1'b0;
      `CHK(gate_cmd, 6'h00)
      `CHK(fault_seen, 1'b1)
      cyc(1000);
      `CHK(gate_cmd, 6'h00)
      `CHK(line, 1'b0)
      `CHK(drive, 6'h00)
      cmd_req = '0;
      cmd_req[2] = 2'h3;
      cyc(200);
      `CHK(line, 1'b1)
      `CHK(gate_cmd, 6'h00)
   endtask : t_fault
   task automatic t_shut();
      // With the enable low nothing may move
      clk_en = 1'b0;
      shutdown_req = 1'b1;
      cyc(4);
      `CHK(oe, 1'b0)
      clk_en = 1'b1;
      cyc(4);
      `CHK(line, 1'b0)
      cyc(130);
      shutdown_req = 1'b0;
      cyc(130);
      `CHK(oe, 1'b0)
      // A one-cycle request must still give a full-width pulse
      shutdown_req = 1'b1;
      cyc(1);
      shutdown_req = 1'b0;
      cyc(HBC_SHUT_CYC - 1);
      `CHK(oe, 1'b1)
      cyc(1);
      `CHK(oe, 1'b0)
      for (int i = 0; i < 3; i++) begin
         period_tick = 1'b1;
         cyc(1);
         period_tick = 1'b0;
         cyc(i == 0 ? 2000 : 100);
         `CHK(period_error, i == 2)
      end
   endtask : t_shut
   always @(posedge ref_clk) begin
      ticks++;
      if (ticks == 8000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      cyc(4);
      reset_n = 1'b1;
      t_dead();
      t_fault();
      t_shut();
      final_report();
   end
endmodule : tb
`default_nettype wire
